// File: rtl/aclr_pkg.sv
// aclr_pkg: offsets, field layouts and fixed values of the access-control
// and latency-report register bank.
// assumes a 32-bit classic Wishbone slave with byte addresses.
package aclr_pkg;

  localparam int          AW                = 12;
  localparam int          DW                = 32;

  localparam logic [11:0] OFF_ECAP_PTR_HDR  = 12'h20C;
  localparam logic [11:0] OFF_ACS_HDR       = 12'h220;
  localparam logic [11:0] OFF_ACS_CAP_CTRL  = 12'h224;
  localparam logic [11:0] OFF_EGRESS_VEC    = 12'h228;
  localparam logic [11:0] OFF_LAT_CAP_HDR   = 12'h230;
  localparam logic [11:0] OFF_MAX_LATENCY   = 12'h234;

  localparam logic [11:0] NEXT_PTR_UP       = 12'h230;
  localparam logic [11:0] NEXT_PTR_DOWN     = 12'h220;
  localparam logic [15:0] PWR_BUDGET_CAP_ID = 16'h0004;
  localparam logic [15:0] ACS_CAP_ID        = 16'h000D;
  localparam logic [15:0] LAT_CAP_ID        = 16'h0018;
  localparam logic [3:0]  CAP_VERSION       = 4'h1;
  localparam logic [11:0] NEXT_PTR_END      = 12'h000;

  localparam logic [6:0]  ACS_FEATURES_IMPL = 7'h7F;
  localparam logic [7:0]  EGRESS_VEC_SIZE   = 8'h08;

  localparam int          ACS_SUP_LSB       = 0;
  localparam int          ACS_SIZE_LSB      = 8;
  localparam int          ACS_SIZE_W        = 8;
  localparam int          ACS_EN_LSB        = 16;
  localparam int          ACS_EN_W          = 7;
  localparam int          EGRESS_W          = 8;
  localparam int          EGRESS_LSB        = 0;
  localparam int          LAT_VAL_W         = 10;
  localparam int          LAT_SCALE_W       = 3;
  localparam int          LAT_FIELD_W       = 13;
  localparam int          SNOOP_LSB         = 0;
  localparam int          NOSNOOP_LSB       = 16;

  localparam logic [6:0]  ACS_EN_RESET      = 7'h00;
  localparam logic [7:0]  EGRESS_RESET      = 8'h00;
  localparam logic [12:0] LAT_RESET         = 13'h0000;
  localparam logic [31:0] ERR_DATA          = 32'h0000_0000;

endpackage

// File: rtl/aclr_regs.sv
// aclr_regs: access-control capability, egress vector and latency
// report registers of one switch port, behind a classic Wishbone slave.
// assumes UPSTREAM is strapped per port and stable after reset release.
`timescale 1ns/1ps
module aclr_regs (
  input  wire logic                  CLK,
  input  wire logic                  NRST,
  input  wire logic                  UPSTREAM,
  input  wire logic                  WB_CYC_I,
  input  wire logic                  WB_STB_I,
  input  wire logic                  WB_WE_I,
  input  wire logic [aclr_pkg::AW-1:0] WB_ADR_I,
  input  wire logic [aclr_pkg::DW-1:0] WB_DAT_I,
  input  wire logic [3:0]            WB_SEL_I,
  output logic      [aclr_pkg::DW-1:0] WB_DAT_O,
  output logic                       WB_ACK_O,
  output logic                       WB_ERR_O,
  output logic      [6:0]            ACS_ENABLES,
  output logic      [7:0]            EGRESS_VECTOR,
  output logic      [12:0]           MAX_SNOOP_LAT,
  output logic      [12:0]           MAX_NOSNOOP_LAT
);
  import aclr_pkg::*;

  // ****************************************************************
  // strap capture
  // ****************************************************************
  logic        up_meta;
  logic        up_sync;
  logic        req;
  logic        take;
  logic        hit;
  logic        wr;
  logic [31:0] rdata;

  logic [ACS_EN_W-1:0]    acs_en;
  logic [EGRESS_W-1:0]    egress;
  logic [LAT_FIELD_W-1:0] snoop;
  logic [LAT_FIELD_W-1:0] nosnoop;
  logic [ACS_EN_W-1:0]    next_acs_en;
  logic [EGRESS_W-1:0]    next_egress;
  logic [LAT_FIELD_W-1:0] next_snoop;
  logic [LAT_FIELD_W-1:0] next_nosnoop;

  // strap comes from a pin; two stages before the decoder sees it
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      up_meta <= 1'b0;
      up_sync <= 1'b0;
    end else begin
      up_meta <= UPSTREAM;
      up_sync <= up_meta;
    end
  end

  // ****************************************************************
  // bus slave and address decode
  // ****************************************************************
  assign req = WB_CYC_I & WB_STB_I;
  assign wr  = take & WB_WE_I & hit;

  always_comb begin
    if (WB_ADR_I == OFF_ECAP_PTR_HDR) begin
      hit = 1'b1;
    end else if (WB_ADR_I == OFF_ACS_HDR) begin
      hit = ~up_sync;
    end else if (WB_ADR_I == OFF_ACS_CAP_CTRL) begin
      hit = ~up_sync;
    end else if (WB_ADR_I == OFF_EGRESS_VEC) begin
      hit = ~up_sync;
    end else if (WB_ADR_I == OFF_LAT_CAP_HDR) begin
      hit = up_sync;
    end else if (WB_ADR_I == OFF_MAX_LATENCY) begin
      hit = up_sync;
    end else begin
      hit = 1'b0;
    end
  end

  aclr_wb_ack u_ack (
    .CLK  (CLK),
    .NRST (NRST),
    .req  (req),
    .hit  (hit),
    .ack  (WB_ACK_O),
    .err  (WB_ERR_O),
    .take (take)
  );

  // ****************************************************************
  // writable fields
  // ****************************************************************
  aclr_wb_byte_merge #(.W(ACS_EN_W), .LSB(ACS_EN_LSB)) u_m_acs (
    .old_val (acs_en),
    .wdat    (WB_DAT_I),
    .sel     (WB_SEL_I),
    .new_val (next_acs_en)
  );
  aclr_wb_byte_merge #(.W(EGRESS_W), .LSB(EGRESS_LSB)) u_m_egr (
    .old_val (egress),
    .wdat    (WB_DAT_I),
    .sel     (WB_SEL_I),
    .new_val (next_egress)
  );
  aclr_wb_byte_merge #(.W(LAT_FIELD_W), .LSB(SNOOP_LSB)) u_m_snp (
    .old_val (snoop),
    .wdat    (WB_DAT_I),
    .sel     (WB_SEL_I),
    .new_val (next_snoop)
  );
  aclr_wb_byte_merge #(.W(LAT_FIELD_W), .LSB(NOSNOOP_LSB)) u_m_nsn (
    .old_val (nosnoop),
    .wdat    (WB_DAT_I),
    .sel     (WB_SEL_I),
    .new_val (next_nosnoop)
  );

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      acs_en <= ACS_EN_RESET;
    end else if (wr && WB_ADR_I == OFF_ACS_CAP_CTRL) begin
      acs_en <= next_acs_en;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      egress <= EGRESS_RESET;
    end else if (wr && WB_ADR_I == OFF_EGRESS_VEC) begin
      egress <= next_egress;
    end
  end

  // latency limits, both halves share one word
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      snoop   <= LAT_RESET;
      nosnoop <= LAT_RESET;
    end else if (wr && WB_ADR_I == OFF_MAX_LATENCY) begin
      snoop   <= next_snoop;
      nosnoop <= next_nosnoop;
    end
  end

  assign ACS_ENABLES     = acs_en;
  assign EGRESS_VECTOR   = egress;
  assign MAX_SNOOP_LAT   = snoop;
  assign MAX_NOSNOOP_LAT = nosnoop;

  // ****************************************************************
  // read path
  // ****************************************************************
  // reserved bits built as zero, read-only bits from constants
  always_comb begin
    rdata = ERR_DATA;
    if (WB_ADR_I == OFF_ECAP_PTR_HDR) begin
      // next pointer depends on port kind
      rdata = {(up_sync ? NEXT_PTR_UP : NEXT_PTR_DOWN), CAP_VERSION, PWR_BUDGET_CAP_ID};
    end else if (WB_ADR_I == OFF_ACS_HDR) begin
      rdata = {NEXT_PTR_END, CAP_VERSION, ACS_CAP_ID};
    end else if (WB_ADR_I == OFF_ACS_CAP_CTRL) begin
      rdata[ACS_SUP_LSB +: ACS_EN_W] = ACS_FEATURES_IMPL;
      rdata[ACS_SIZE_LSB +: ACS_SIZE_W] = EGRESS_VEC_SIZE;
      rdata[ACS_EN_LSB +: ACS_EN_W]  = acs_en;
    end else if (WB_ADR_I == OFF_EGRESS_VEC) begin
      rdata[EGRESS_LSB +: EGRESS_W] = egress;
    end else if (WB_ADR_I == OFF_LAT_CAP_HDR) begin
      rdata = {NEXT_PTR_END, CAP_VERSION, LAT_CAP_ID};
    end else if (WB_ADR_I == OFF_MAX_LATENCY) begin
      rdata[SNOOP_LSB +: LAT_FIELD_W]   = snoop;
      rdata[NOSNOOP_LSB +: LAT_FIELD_W] = nosnoop;
    end
  end

  // data registered with the answer; unmapped reads give zero
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      WB_DAT_O <= ERR_DATA;
    end else if (take) begin
      WB_DAT_O <= hit ? rdata : ERR_DATA;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  acs_cap_ro_a : assert property (@(posedge CLK) disable iff (!NRST)
    (take && hit && !WB_WE_I && WB_ADR_I == OFF_ACS_CAP_CTRL) |=>
    (WB_DAT_O[15:0] == {EGRESS_VEC_SIZE, 1'b0, ACS_FEATURES_IMPL}))
    else $error("capability read-only bits wrong");

  acs_en_write_a : assert property (@(posedge CLK) disable iff (!NRST)
    (wr && WB_ADR_I == OFF_ACS_CAP_CTRL && WB_SEL_I[2]) |=>
    (ACS_ENABLES == $past(WB_DAT_I[22:16])))
    else $error("enable bits not written");

  acs_en_hold_a : assert property (@(posedge CLK) disable iff (!NRST)
    !(wr && WB_ADR_I == OFF_ACS_CAP_CTRL) |=> $stable(ACS_ENABLES))
    else $error("enable bits changed without write");

  egress_write_a : assert property (@(posedge CLK) disable iff (!NRST)
    (wr && WB_ADR_I == OFF_EGRESS_VEC && WB_SEL_I[0]) |=>
    (EGRESS_VECTOR == $past(WB_DAT_I[7:0])))
    else $error("egress vector not written");

  egress_down_a : assert property (@(posedge CLK) disable iff (!NRST)
    (take && up_sync && WB_ADR_I == OFF_EGRESS_VEC) |=> (WB_ERR_O && !WB_ACK_O))
    else $error("egress offset answered on upstream port");

  lat_hdr_a : assert property (@(posedge CLK) disable iff (!NRST)
    (take && up_sync && WB_ADR_I == OFF_LAT_CAP_HDR) |=>
    (WB_ACK_O && WB_DAT_O == 32'h0001_0018))
    else $error("latency header wrong");

  lat_down_a : assert property (@(posedge CLK) disable iff (!NRST)
    (take && !up_sync && WB_ADR_I == OFF_MAX_LATENCY) |=> WB_ERR_O ##1 !WB_ERR_O)
    else $error("latency offset answered on downstream port");

  lat_reserved_a : assert property (@(posedge CLK) disable iff (!NRST)
    (take && hit && WB_ADR_I == OFF_MAX_LATENCY) |=>
    (WB_DAT_O[31:29] == 3'h0 && WB_DAT_O[15:13] == 3'h0))
    else $error("reserved latency bits nonzero");

  next_ptr_a : assert property (@(posedge CLK) disable iff (!NRST)
    (take && WB_ADR_I == OFF_ECAP_PTR_HDR) |=>
    (WB_DAT_O[31:20] == ($past(up_sync) ? NEXT_PTR_UP : NEXT_PTR_DOWN)))
    else $error("next pointer wrong");

  snoop_write_a : assert property (@(posedge CLK) disable iff (!NRST)
    (wr && WB_ADR_I == OFF_MAX_LATENCY && WB_SEL_I == 4'hF) |=>
    (MAX_SNOOP_LAT == $past(WB_DAT_I[12:0]) && MAX_NOSNOOP_LAT == $past(WB_DAT_I[28:16])))
    else $error("latency fields not written");

  // ****************************************************************
  // assertions on read data, port kind and bus answers
  // ****************************************************************
  // bus answers are one pulse per request, never both kinds at once
  acs_en_read_a : assert property (@(posedge CLK) disable iff (!NRST)
    (take && hit && !WB_WE_I && WB_ADR_I == OFF_ACS_CAP_CTRL) |=>
    (WB_DAT_O[22:16] == $past(ACS_ENABLES)))
    else $error("enable bits read back wrong");

  acs_lane_a : assert property (@(posedge CLK) disable iff (!NRST)
    (wr && WB_ADR_I == OFF_ACS_CAP_CTRL && !WB_SEL_I[2]) |=> $stable(ACS_ENABLES))
    else $error("enable bits changed without their byte lane");

  acs_up_err_a : assert property (@(posedge CLK) disable iff (!NRST)
    (take && up_sync && WB_ADR_I == OFF_ACS_CAP_CTRL) |=>
    (WB_ERR_O && !WB_ACK_O && $stable(ACS_ENABLES)))
    else $error("capability offset answered on upstream port");

  acs_reserved_a : assert property (@(posedge CLK) disable iff (!NRST)
    (take && hit && WB_ADR_I == OFF_ACS_CAP_CTRL) |=>
    (WB_DAT_O[31:23] == 9'h000 && WB_DAT_O[7] == 1'b0))
    else $error("reserved capability bits nonzero");

  egress_read_a : assert property (@(posedge CLK) disable iff (!NRST)
    (take && hit && !WB_WE_I && WB_ADR_I == OFF_EGRESS_VEC) |=>
    (WB_DAT_O == {24'h00_0000, $past(EGRESS_VECTOR)}))
    else $error("egress vector read back wrong");

  egress_hold_a : assert property (@(posedge CLK) disable iff (!NRST)
    !(wr && WB_ADR_I == OFF_EGRESS_VEC) |=> $stable(EGRESS_VECTOR))
    else $error("egress vector changed without write");

  lat_up_only_a : assert property (@(posedge CLK) disable iff (!NRST)
    (take && !up_sync && WB_ADR_I == OFF_LAT_CAP_HDR) |=>
    (WB_ERR_O && !WB_ACK_O && WB_DAT_O == ERR_DATA))
    else $error("latency header answered on downstream port");

  lat_ver_a : assert property (@(posedge CLK) disable iff (!NRST)
    (take && hit && WB_ADR_I == OFF_LAT_CAP_HDR) |=> (WB_DAT_O[19:16] == 4'h1))
    else $error("latency header version wrong");

  lat_next_a : assert property (@(posedge CLK) disable iff (!NRST)
    (take && hit && WB_ADR_I == OFF_LAT_CAP_HDR) |=> (WB_DAT_O[31:20] == 12'h000))
    else $error("latency header next pointer wrong");

  snoop_read_a : assert property (@(posedge CLK) disable iff (!NRST)
    (take && hit && !WB_WE_I && WB_ADR_I == OFF_MAX_LATENCY) |=>
    (WB_DAT_O[12:0] == $past(MAX_SNOOP_LAT)))
    else $error("snoop latency read back wrong");

  nosnoop_read_a : assert property (@(posedge CLK) disable iff (!NRST)
    (take && hit && !WB_WE_I && WB_ADR_I == OFF_MAX_LATENCY) |=>
    (WB_DAT_O[28:16] == $past(MAX_NOSNOOP_LAT)))
    else $error("no-snoop latency read back wrong");

  lat_hold_a : assert property (@(posedge CLK) disable iff (!NRST)
    !(wr && WB_ADR_I == OFF_MAX_LATENCY) |=>
    ($stable(MAX_SNOOP_LAT) && $stable(MAX_NOSNOOP_LAT)))
    else $error("latency fields changed without write");

  unmapped_err_a : assert property (@(posedge CLK) disable iff (!NRST)
    (take && !hit) |=> (WB_ERR_O && !WB_ACK_O && WB_DAT_O == ERR_DATA))
    else $error("unmapped offset not refused");

  read_hold_a : assert property (@(posedge CLK) disable iff (!NRST)
    !take |=> $stable(WB_DAT_O))
    else $error("read data changed without a request");

  mapped_ack_a : assert property (@(posedge CLK) disable iff (!NRST)
    (take && hit) |=> (WB_ACK_O && !WB_ERR_O))
    else $error("mapped offset not acknowledged");

  answer_once_a : assert property (@(posedge CLK) disable iff (!NRST)
    (WB_ACK_O || WB_ERR_O) |=> !(WB_ACK_O || WB_ERR_O))
    else $error("answer held longer than one cycle");

  answer_excl_a : assert property (@(posedge CLK) disable iff (!NRST)
    !(WB_ACK_O && WB_ERR_O))
    else $error("acknowledge and error raised together");

  acs_hdr_a : assert property (@(posedge CLK) disable iff (!NRST)
    (take && !up_sync && WB_ADR_I == OFF_ACS_HDR) |=>
    (WB_ACK_O && WB_DAT_O == 32'h0001_000D))
    else $error("access-control header wrong");

  ptr_hdr_a : assert property (@(posedge CLK) disable iff (!NRST)
    (take && WB_ADR_I == OFF_ECAP_PTR_HDR) |=> (WB_ACK_O && WB_DAT_O[19:0] == 20'h1_0004))
    else $error("preceding header low fields wrong");

endmodule

// File: rtl/aclr_wb_ack.sv
// aclr_wb_ack: single-cycle classic Wishbone answer generator.
// assumes the master holds cyc and stb until it sees ack or err.
`timescale 1ns/1ps
module aclr_wb_ack (
  input  wire logic CLK,
  input  wire logic NRST,
  input  wire logic req,
  input  wire logic hit,
  output logic      ack,
  output logic      err,
  output logic      take
);
  logic busy;

  // one answer per request; busy blocks a second answer on the held strobe
  assign take = req & ~busy;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      busy <= 1'b0;
    end else begin
      busy <= take;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ack <= 1'b0;
      err <= 1'b0;
    end else begin
      ack <= take & hit;
      err <= take & ~hit;
    end
  end
endmodule

// File: rtl/aclr_wb_byte_merge.sv
// aclr_wb_byte_merge: merges Wishbone write data into a stored field
// under byte selects, keeping the unselected bytes.
// assumes the field sits at bit lsb of the 32-bit bus word.
`timescale 1ns/1ps
module aclr_wb_byte_merge #(
  parameter int W   = 8,
  parameter int LSB = 0
) (
  input  wire logic [W-1:0]  old_val,
  input  wire logic [31:0]   wdat,
  input  wire logic [3:0]    sel,
  output logic      [W-1:0]  new_val
);
  always_comb begin
    for (int i = 0; i < W; i++) begin
      new_val[i] = sel[(LSB + i) / 8] ? wdat[LSB + i] : old_val[i];
    end
  end
endmodule

// File: verification/testbench.sv
// testbench: self-checking bench for the access-control and latency register bank.
// assumes aclr_pkg and the design files are compiled first; one 100 MHz clock.
`timescale 1ns/1ps
module testbench;
  import aclr_pkg::*;

  // ************************************************************
  // signals and model state
  // ************************************************************
  logic        clk;
  logic        nrst;
  logic        upstream;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [11:0] adr;
  logic [31:0] wdat;
  logic [3:0]  sel;
  logic [31:0] dat_o;
  logic        ack_o;
  logic        err_o;
  logic [6:0]  acs_en;
  logic [7:0]  egress;
  logic [12:0] snoop;
  logic [12:0] nosnoop;
  logic [31:0] rd;
  logic        rerr;
  logic        rack;
  logic [31:0] d;
  int          n_mismatch;
  int          num_checks;
  int          ncyc;
  int          m_acs;
  int          m_egr;
  int          m_lat;
  integer      seed;

  aclr_regs dut (
    .CLK(clk), .NRST(nrst), .UPSTREAM(upstream), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_DAT_I(wdat), .WB_SEL_I(sel), .WB_DAT_O(dat_o),
    .WB_ACK_O(ack_o), .WB_ERR_O(err_o), .ACS_ENABLES(acs_en), .EGRESS_VECTOR(egress),
    .MAX_SNOOP_LAT(snoop), .MAX_NOSNOOP_LAT(nosnoop)
  );

  always #5 clk = ~clk;

  // ************************************************************
  // tasks
  // ************************************************************
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk_dat(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t data got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_err(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t flag got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one classic cycle; waits for ack or err, takes data at that edge
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] dd,
                    input logic [3:0] s);
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= dd;
    sel  <= s;
    // ack or err ends this wait; with neither, only the bench timeout ends it
    do begin
      @(posedge clk);
    end while (!(ack_o === 1'b1 || err_o === 1'b1));
    rd   = dat_o;
    rerr = err_o;
    rack = ack_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic experr);
    wb(1'b0, a, 32'h0000_0000, 4'hF);
    chk_err(rerr, experr);
    chk_err(rack, !experr);
    chk_dat(rd, exp);
  endtask

  // the strap is only sampled after release, so it changes while reset is held
  task automatic do_reset(input logic up);
    @(posedge clk);
    nrst     <= 1'b0;
    upstream <= up;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    m_acs = 0;
    m_egr = 0;
    m_lat = 0;
  endtask

  function automatic int merge(int old, logic [31:0] dd, logic [3:0] s, int fm);
    int bm;
    bm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}} & fm;
    return (old & ~bm) | (dd & bm);
  endfunction

  always @(posedge clk) begin
    ncyc++;
    if (ncyc == 5000) begin
      n_mismatch++;
      $display("ERROR t=%0t timeout got=%h exp=%h", $time, ncyc, 0);
      give_verdict();
    end
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    clk = 0;
    nrst = 0;
    upstream = 0;
    cyc = 0;
    stb = 0;
    we = 0;
    adr = 12'h000;
    wdat = 32'h0000_0000;
    sel = 4'h0;
    n_mismatch = 0;
    num_checks = 0;
    ncyc = 0;
    seed = 32'hB35029B5;
    do_reset(1'b0);
    rdchk(12'h20C, 32'h2201_0004, 1'b0);
    rdchk(12'h220, 32'h0001_000D, 1'b0);
    rdchk(12'h224, 32'h0000_087F, 1'b0);
    rdchk(12'h228, 32'h0000_0000, 1'b0);
    rdchk(12'h230, 32'h0000_0000, 1'b1);
    rdchk(12'h234, 32'h0000_0000, 1'b1);
    rdchk(12'h300, 32'h0000_0000, 1'b1);
    wb(1'b1, 12'h224, 32'hFFFF_FFFF, 4'hF);
    m_acs = merge(m_acs, 32'hFFFF_FFFF, 4'hF, 32'h007F_0000);
    rdchk(12'h224, 32'h007F_087F, 1'b0);
    for (int i = 0; i < 8; i++) begin
      d = $random(seed);
      wb(1'b1, 12'h224, d, 4'(i * 5 + 3));
      m_acs = merge(m_acs, d, 4'(i * 5 + 3), 32'h007F_0000);
      d = $random(seed);
      wb(1'b1, 12'h228, d, 4'(i * 3 + 1));
      m_egr = merge(m_egr, d, 4'(i * 3 + 1), 32'h0000_00FF);
      wb(1'b1, 12'h234, d, 4'hF);
      chk_err(rerr, 1'b1);
      chk_dat({19'h0, snoop}, 32'h0000_0000);
      rdchk(12'h224, 32'h0000_087F | m_acs, 1'b0);
      rdchk(12'h228, m_egr, 1'b0);
      chk_dat({25'h0, acs_en}, m_acs >> 16);
      chk_dat({24'h0, egress}, m_egr);
    end
    $display("test downstream done");
    do_reset(1'b1);
    chk_dat({24'h0, egress}, 32'h0000_0000);
    chk_dat({25'h0, acs_en}, 32'h0000_0000);
    rdchk(12'h20C, 32'h2301_0004, 1'b0);
    rdchk(12'h230, 32'h0001_0018, 1'b0);
    rdchk(12'h234, 32'h0000_0000, 1'b0);
    rdchk(12'h220, 32'h0000_0000, 1'b1);
    rdchk(12'h224, 32'h0000_0000, 1'b1);
    rdchk(12'h228, 32'h0000_0000, 1'b1);
    wb(1'b1, 12'h230, 32'hFFFF_FFFF, 4'hF);
    rdchk(12'h230, 32'h0001_0018, 1'b0);
    wb(1'b1, 12'h224, 32'hFFFF_FFFF, 4'hF);
    chk_err(rerr, 1'b1);
    chk_dat({25'h0, acs_en}, 32'h0000_0000);
    for (int i = 0; i < 10; i++) begin
      d = (i == 0) ? 32'hFFFF_FFFF : $random(seed);
      wb(1'b1, 12'h234, d, (i == 0) ? 4'hF : 4'($random(seed)));
      m_lat = merge(m_lat, d, sel, 32'h1FFF_1FFF);
      rdchk(12'h234, m_lat, 1'b0);
      chk_dat({19'h0, snoop}, m_lat & 32'h1FFF);
      chk_dat({19'h0, nosnoop}, m_lat >> 16);
    end
    $display("test upstream done");
    give_verdict();
  end
endmodule
